// [mfx_pkg.sv]
package mfx_pkg;
	// field widths
	localparam int FW = 3;
	localparam int AW = 12;
	// instruction phase codes, one-hot
	typedef enum logic [2:0] {
		PH_FETCH = 3'h1,
		PH_DEFER = 3'h2,
		PH_EXEC = 3'h4
	} mfx_phase_t;
	// top three instruction bits: memory reference classes
	localparam logic [2:0] OPC_AND = 3'h0;
	localparam logic [2:0] OPC_DCA = 3'h3;
	// iot word layout: device 2N, function bits 2:0
	localparam logic [5:0] IOT_HI = 6'h32; // octal 62
	localparam logic [2:0] IOT_OPF_CDF = 3'h1;
	localparam logic [2:0] IOT_OPF_CIF = 3'h2;
	localparam logic [2:0] IOT_OPF_BOTH = 3'h3;
	localparam logic [2:0] IOT_OPF_READ = 3'h4;
	// sub codes (field N) for the read group 62N4
	localparam logic [2:0] RD_OPERAND = 3'h1;
	localparam logic [2:0] RD_CODE = 3'h2;
	localparam logic [2:0] RD_SAVED = 3'h3;
	localparam logic [2:0] RD_RESTORE = 3'h4;
	localparam logic [2:0] RD_COMMIT = 3'h5;
	// get-flags word, octal 6004
	localparam logic [11:0] IOT_GET_FLAGS = 12'hc04;
	// auto-index window 10..17 octal: address bits 11:3 equal one
	localparam logic [8:0] AUTOIDX_PAGE = 9'h001;
	// register map
	localparam logic [11:0] REG_STATUS = 12'h000;
	localparam logic [11:0] REG_CTRL = 12'h004;
	localparam logic [31:0] CTRL_RESET = 32'h00000001;
	// status field positions
	localparam int ST_IF = 0;
	localparam int ST_IB = 4;
	localparam int ST_DF = 8;
	localparam int ST_SF = 12;
	localparam int ST_INH = 20;
	// processor core request carrier
	typedef struct packed {
		logic iot_stb;
		logic [AW-1:0] iot_word;
		logic [AW-1:0] acc;
		mfx_phase_t phase;
		logic phase_stb;
		logic [2:0] opc;
		logic [AW-1:0] addr;
		logic jump_exec;
		logic int_ack;
		logic int_req;
		logic panel_req;
		logic panel_mode;
	} mfx_cpu_req_t;
	// apb request carrier
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} mfx_apb_req_t;
endpackage : mfx_pkg

// [mfx_memory_field_extension.sv]
`timescale 1ns/10ps
module mfx_memory_field_extension (
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	input wire mfx_pkg::mfx_cpu_req_t CPU_REQ_IN,
	input wire mfx_pkg::mfx_apb_req_t APB_REQ_IN,
	output logic [mfx_pkg::FW-1:0] EXT_FIELD_OUT,
	output logic AUTOIDX_OUT,
	output logic [mfx_pkg::AW-1:0] ACC_OUT,
	output logic ACC_VALID_OUT,
	output logic INT_GRANT_OUT,
	output logic PANEL_GRANT_OUT,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT
);

	////////////////////////////////////////////////////////////////
	// field state
	logic [mfx_pkg::FW-1:0] code_field_q;
	logic [mfx_pkg::FW-1:0] instruction_field_buffer_q;
	logic [mfx_pkg::FW-1:0] data_field_q;
	logic [2*mfx_pkg::FW-1:0] save_field_q;
	logic inhibit_q;
	logic [31:0] ctrl_q;
	mfx_pkg::mfx_phase_t last_phase_q;

	// iot decode
	logic iot_ours;
	logic [2:0] iot_n;
	logic [2:0] iot_f;
	logic do_set_operand;
	logic do_switch_code;
	logic do_read;
	logic do_restore;
	logic do_commit;
	logic do_get_flags;
	logic jump_commit;

	assign iot_ours = CPU_REQ_IN.iot_stb && (CPU_REQ_IN.iot_word[11:6] == mfx_pkg::IOT_HI);
	assign iot_n = CPU_REQ_IN.iot_word[5:3];
	assign iot_f = CPU_REQ_IN.iot_word[2:0];
	assign do_set_operand = iot_ours && (iot_f == mfx_pkg::IOT_OPF_CDF || iot_f == mfx_pkg::IOT_OPF_BOTH);
	assign do_switch_code = iot_ours && (iot_f == mfx_pkg::IOT_OPF_CIF || iot_f == mfx_pkg::IOT_OPF_BOTH);
	assign do_read = iot_ours && (iot_f == mfx_pkg::IOT_OPF_READ);
	assign do_restore = do_read && (iot_n == mfx_pkg::RD_RESTORE);
	assign do_commit = do_read && (iot_n == mfx_pkg::RD_COMMIT);
	assign do_get_flags = CPU_REQ_IN.iot_stb && (CPU_REQ_IN.iot_word == mfx_pkg::IOT_GET_FLAGS);
	// panel routines must run transparently, so jumps there keep the field
	assign jump_commit = CPU_REQ_IN.jump_exec && !CPU_REQ_IN.panel_mode;

	////////////////////////////////////////////////////////////////
	// active code field: moves only on commit points and interrupt entry, never on pc carry
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			code_field_q <= '0;
		end else if (CPU_REQ_IN.int_ack) begin
			code_field_q <= '0;
		end else if (do_commit) begin
			code_field_q <= instruction_field_buffer_q;
		end else if (jump_commit) begin
			code_field_q <= instruction_field_buffer_q;
		end
		// no path increments the field on a pc wrap
	end

	// buffer: written by switch and restore, cleared on interrupt entry
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			instruction_field_buffer_q <= '0;
		end else if (CPU_REQ_IN.int_ack) begin
			instruction_field_buffer_q <= '0;
		end else if (do_switch_code) begin
			instruction_field_buffer_q <= iot_n;
		end else if (do_restore) begin
			instruction_field_buffer_q <= save_field_q[2*mfx_pkg::FW-1:mfx_pkg::FW];
		end
	end

	// operand field: jumps do not touch it
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			data_field_q <= '0;
		end else if (CPU_REQ_IN.int_ack) begin
			data_field_q <= '0;
		end else if (do_set_operand) begin
			data_field_q <= iot_n;
		end else if (do_restore) begin
			data_field_q <= save_field_q[mfx_pkg::FW-1:0];
		end
		// jump_commit deliberately absent here
	end

	// save field captures buffer, not active field, so a pending switch survives
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			save_field_q <= '0;
		end else if (CPU_REQ_IN.int_ack) begin
			save_field_q <= {instruction_field_buffer_q, data_field_q};
		end
	end

	// interrupt inhibit flip-flop; set wins if both arrive together
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			inhibit_q <= 1'b0;
		end else if (do_switch_code || do_restore) begin
			inhibit_q <= 1'b1;
		end else if (do_commit || jump_commit) begin
			inhibit_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// phase tracking: operand field only in execute right after defer
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			last_phase_q <= mfx_pkg::PH_FETCH;
		end else if (CPU_REQ_IN.phase_stb) begin
			last_phase_q <= CPU_REQ_IN.phase;
		end
	end

	// extension bits for the cycle the core announces
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			EXT_FIELD_OUT <= '0;
			AUTOIDX_OUT <= 1'b0;
		end else if (CPU_REQ_IN.phase_stb) begin
			// field zero keeps its auto-index words even with the extension off
			AUTOIDX_OUT <= (CPU_REQ_IN.phase == mfx_pkg::PH_DEFER)
				&& (CPU_REQ_IN.addr[11:3] == mfx_pkg::AUTOIDX_PAGE);
			if (!ctrl_q[0]) begin
				EXT_FIELD_OUT <= '0; // extension disabled: field zero only
			end else begin
				case (CPU_REQ_IN.phase)
					mfx_pkg::PH_FETCH: begin
						EXT_FIELD_OUT <= code_field_q;
					end
					mfx_pkg::PH_DEFER: begin
						EXT_FIELD_OUT <= code_field_q;
					end
					mfx_pkg::PH_EXEC: begin
						if (last_phase_q == mfx_pkg::PH_DEFER && CPU_REQ_IN.opc <= mfx_pkg::OPC_DCA) begin
							EXT_FIELD_OUT <= data_field_q;
						end else begin
							EXT_FIELD_OUT <= code_field_q;
						end
					end
					default: begin
						EXT_FIELD_OUT <= code_field_q;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// accumulator answers to read instructions; other bits pass unchanged
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			ACC_OUT <= '0;
			ACC_VALID_OUT <= 1'b0;
		end else begin
			ACC_VALID_OUT <= 1'b0;
			if (do_get_flags) begin
				ACC_OUT <= CPU_REQ_IN.acc | {6'h00, save_field_q};
				ACC_VALID_OUT <= 1'b1;
			end else if (do_read && iot_n == mfx_pkg::RD_OPERAND) begin
				ACC_OUT <= CPU_REQ_IN.acc | {6'h00, data_field_q, 3'h0};
				ACC_VALID_OUT <= 1'b1;
			end else if (do_read && iot_n == mfx_pkg::RD_CODE) begin
				ACC_OUT <= CPU_REQ_IN.acc | {6'h00, code_field_q, 3'h0};
				ACC_VALID_OUT <= 1'b1;
			end else if (do_read && iot_n == mfx_pkg::RD_SAVED) begin
				ACC_OUT <= CPU_REQ_IN.acc | {6'h00, save_field_q};
				ACC_VALID_OUT <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupt gating; panel requests skip both the field match and the inhibit
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			INT_GRANT_OUT <= 1'b0;
			PANEL_GRANT_OUT <= 1'b0;
		end else begin
			INT_GRANT_OUT <= CPU_REQ_IN.int_req && !inhibit_q
				&& (code_field_q == instruction_field_buffer_q);
			PANEL_GRANT_OUT <= CPU_REQ_IN.panel_req;
		end
	end

	////////////////////////////////////////////////////////////////
	// apb slave: one wait state, pready registered
	logic apb_access;
	logic apb_hit_status;
	logic apb_hit_ctrl;
	logic [31:0] status_word;

	assign apb_access = APB_REQ_IN.psel && APB_REQ_IN.penable && !PREADY_OUT;
	assign apb_hit_status = (APB_REQ_IN.paddr == mfx_pkg::REG_STATUS);
	assign apb_hit_ctrl = (APB_REQ_IN.paddr == mfx_pkg::REG_CTRL);

	always_comb begin
		status_word = '0;
		status_word[mfx_pkg::ST_IF +: mfx_pkg::FW] = code_field_q;
		status_word[mfx_pkg::ST_IB +: mfx_pkg::FW] = instruction_field_buffer_q;
		status_word[mfx_pkg::ST_DF +: mfx_pkg::FW] = data_field_q;
		status_word[mfx_pkg::ST_SF +: 2*mfx_pkg::FW] = save_field_q;
		status_word[mfx_pkg::ST_INH] = inhibit_q;
	end

	// control register; bit 0 enables the field extension
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			ctrl_q <= mfx_pkg::CTRL_RESET;
		end else if (apb_access && APB_REQ_IN.pwrite && apb_hit_ctrl) begin
			ctrl_q <= {31'h00000000, APB_REQ_IN.pwdata[0]};
		end
	end

	// answer path; unmapped addresses flag an error and read zero
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			PREADY_OUT <= 1'b0;
			PSLVERR_OUT <= 1'b0;
			PRDATA_OUT <= '0;
		end else begin
			PREADY_OUT <= apb_access;
			PSLVERR_OUT <= apb_access && !apb_hit_status && !apb_hit_ctrl;
			if (apb_access && !APB_REQ_IN.pwrite) begin
				PRDATA_OUT <= apb_hit_status ? status_word : (apb_hit_ctrl ? ctrl_q : 32'h00000000);
			end else begin
				PRDATA_OUT <= '0;
			end
		end
	end

endmodule : mfx_memory_field_extension

// [mfx_core_model.sv]
`timescale 1ns/10ps
// processor core stand-in: strobes last one cycle, levels hold until changed
module mfx_core_model (
	input wire logic clk_in,
	output mfx_pkg::mfx_cpu_req_t req_out
);
	initial req_out = '0;
	////////////////////////////////////////////////////////////
	// every strobe is dropped one edge after it was raised
	task fin;
		@(posedge clk_in);
		req_out.iot_stb <= 1'b0;
		req_out.phase_stb <= 1'b0;
		req_out.jump_exec <= 1'b0;
		req_out.int_ack <= 1'b0;
	endtask : fin
	task iot(input logic [11:0] w, input logic [11:0] a);
		@(posedge clk_in);
		req_out.iot_stb <= 1'b1;
		req_out.iot_word <= w;
		req_out.acc <= a;
		fin;
	endtask : iot
	// opc and addr stay put after the strobe, like a real core bus
	task ph(input mfx_pkg::mfx_phase_t p, input logic [2:0] o, input logic [11:0] a);
		@(posedge clk_in);
		req_out.phase_stb <= 1'b1;
		req_out.phase <= p;
		req_out.opc <= o;
		req_out.addr <= a;
		fin;
	endtask : ph
	task jump_op;
		@(posedge clk_in);
		req_out.jump_exec <= 1'b1;
		fin;
	endtask : jump_op
	task ack;
		@(posedge clk_in);
		req_out.int_ack <= 1'b1;
		fin;
	endtask : ack
	task lvl(input logic i, input logic p, input logic m);
		@(posedge clk_in);
		req_out.int_req <= i;
		req_out.panel_req <= p;
		req_out.panel_mode <= m;
	endtask : lvl
endmodule : mfx_core_model

// [mfx_memory_field_extension_chk.sv]
`timescale 1ns/10ps
module mfx_field_chk (
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	input wire mfx_pkg::mfx_cpu_req_t CPU_REQ_IN,
	input wire mfx_pkg::mfx_apb_req_t APB_REQ_IN,
	input wire logic [mfx_pkg::FW-1:0] EXT_FIELD_OUT,
	input wire logic AUTOIDX_OUT,
	input wire logic [mfx_pkg::AW-1:0] ACC_OUT,
	input wire logic ACC_VALID_OUT,
	input wire logic INT_GRANT_OUT,
	input wire logic PANEL_GRANT_OUT,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	mfx_pkg::mfx_cpu_req_t c;
	logic hi, sw, rd_f, rd_s, go, fld_q;
	logic [11:0] acc_q;
	////////////////////////////////////////////////////////////
	// iot decode; reads are answered and switches still set the inhibit beside an interrupt entry
	assign c = CPU_REQ_IN;
	assign hi = c.iot_stb && c.iot_word[11:6] == mfx_pkg::IOT_HI;
	assign sw = hi && c.iot_word[2:1] == 2'h1;
	assign rd_f = hi && c.iot_word[2:0] == mfx_pkg::IOT_OPF_READ && c.iot_word[5:4] == 2'h0 && c.iot_word[3:3] != 1'b0
		|| hi && c.iot_word[2:0] == mfx_pkg::IOT_OPF_READ && c.iot_word[5:3] == mfx_pkg::RD_CODE;
	assign rd_s = hi && c.iot_word[2:0] == mfx_pkg::IOT_OPF_READ && c.iot_word[5:3] == mfx_pkg::RD_SAVED
		|| c.iot_stb && c.iot_word == mfx_pkg::IOT_GET_FLAGS;
	assign go = APB_REQ_IN.psel && APB_REQ_IN.penable && !PREADY_OUT;
	// remember the accumulator a read started from, to judge the answer
	always_ff @(posedge CLK_IN) begin
		if (rd_f || rd_s) begin
			acc_q <= c.acc;
			fld_q <= rd_f;
		end
	end
	sequence s_calm;
		!c.jump_exec && !c.int_ack && !c.iot_stb;
	endsequence
	sequence s_entry;
		c.int_ack ##1 s_calm ##1 (c.phase_stb ##0 s_calm);
	endsequence
	a_switch_blocks_int: assert property (sw ##1 s_calm |=> !INT_GRANT_OUT)
		else $error("interrupt granted right after a code field switch");
	a_entry_field_zero: assert property (s_entry |=> EXT_FIELD_OUT == 3'h0)
		else $error("field not zero after interrupt entry");
	a_read_answers: assert property ((rd_f || rd_s) |=> ##[0:1] ACC_VALID_OUT)
		else $error("read iot gave no accumulator answer");
	a_read_keeps_acc: assert property (ACC_VALID_OUT |-> (ACC_OUT & acc_q) == acc_q
		&& (!fld_q || ACC_OUT[11:6] == acc_q[11:6] && ACC_OUT[2:0] == acc_q[2:0]))
		else $error("read disturbed accumulator bits");
	a_autoidx_window: assert property (c.phase_stb && c.phase == mfx_pkg::PH_DEFER
		&& c.addr[11:3] == mfx_pkg::AUTOIDX_PAGE |=> AUTOIDX_OUT)
		else $error("auto-index address not flagged");
	a_panel_granted: assert property (c.panel_req |=> PANEL_GRANT_OUT)
		else $error("panel request not granted");
	a_apb_ready_once: assert property (go |=> PREADY_OUT ##1 !PREADY_OUT)
		else $error("apb ready not a single pulse after access");
	a_apb_unmapped: assert property (go && APB_REQ_IN.paddr != mfx_pkg::REG_STATUS
		&& APB_REQ_IN.paddr != mfx_pkg::REG_CTRL |=> PSLVERR_OUT)
		else $error("unmapped apb access without error");
endmodule : mfx_field_chk
bind mfx_memory_field_extension mfx_field_chk u_chk (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .CPU_REQ_IN(CPU_REQ_IN),
	.APB_REQ_IN(APB_REQ_IN), .EXT_FIELD_OUT(EXT_FIELD_OUT), .AUTOIDX_OUT(AUTOIDX_OUT), .ACC_OUT(ACC_OUT),
	.ACC_VALID_OUT(ACC_VALID_OUT), .INT_GRANT_OUT(INT_GRANT_OUT), .PANEL_GRANT_OUT(PANEL_GRANT_OUT),
	.PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT));

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
	logic clk, rst_n, aidx, accv, igr, pgr, prdy, perr, e;
	logic [2:0] ext;
	logic [11:0] acc;
	logic [31:0] prd, r;
	mfx_pkg::mfx_cpu_req_t cpu;
	mfx_pkg::mfx_apb_req_t apb_q;
	int fail_count, n_checks;
	mfx_memory_field_extension u_mfx_memory_field_extension (.CLK_IN(clk), .RSTN_IN(rst_n), .CPU_REQ_IN(cpu),
		.APB_REQ_IN(apb_q), .EXT_FIELD_OUT(ext), .AUTOIDX_OUT(aidx), .ACC_OUT(acc), .ACC_VALID_OUT(accv),
		.INT_GRANT_OUT(igr), .PANEL_GRANT_OUT(pgr), .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr));
	mfx_core_model u_mfx_core_model (.clk_in(clk), .req_out(cpu));
	////////////////////////////////////////////////////////////
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	// announce a phase and judge the field presented for it
	task phx(input logic [2:0] p, input logic [2:0] o, input logic [11:0] a, input logic [2:0] x);
		u_mfx_core_model.ph(mfx_pkg::mfx_phase_t'(p), o, a);
		@(posedge clk);
		check(ext, x);
	endtask : phx
	// latency of the answer is waited out, not assumed; only the watchdog ends a wait
	task rd(input logic [11:0] w, input logic [11:0] a, input logic [11:0] x);
		u_mfx_core_model.iot(w, a);
		while (accv !== 1'b1) begin
			@(posedge clk);
		end
		check(acc, x);
	endtask : rd
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		apb_q.penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (prdy !== 1'b1);
		r = prd;
		e = perr;
		apb_q <= '0;
	endtask : apb
	task t_fields;
		u_mfx_core_model.iot(12'hca9, 12'h000);
		u_mfx_core_model.iot(12'hc9a, 12'h000);
		phx(3'h1, 3'h1, 12'h200, 3'h0);
		phx(3'h2, 3'h1, 12'h008, 3'h0);
		check(aidx, 1'b1);
		phx(3'h4, 3'h1, 12'h300, 3'h5);
		u_mfx_core_model.jump_op;
		phx(3'h1, 3'h0, 12'h201, 3'h3);
		phx(3'h4, 3'h0, 12'h050, 3'h3);
		phx(3'h1, 3'h3, 12'h202, 3'h3);
		phx(3'h2, 3'h3, 12'h010, 3'h3);
		check(aidx, 1'b0);
		phx(3'h4, 3'h3, 12'h300, 3'h5);
	endtask : t_fields
	task t_int;
		u_mfx_core_model.lvl(1'b1, 1'b0, 1'b0);
		u_mfx_core_model.iot(12'hc8a, 12'h000);
		repeat (3) @(posedge clk);
		check(igr, 1'b0);
		u_mfx_core_model.jump_op;
		repeat (2) @(posedge clk);
		check(igr, 1'b1);
		u_mfx_core_model.iot(12'hca2, 12'h000);
		u_mfx_core_model.ack;
		phx(3'h1, 3'h0, 12'h001, 3'h0);
		rd(12'hc9c, 12'h000, 12'h025);
		rd(12'hc04, 12'h800, 12'h825);
		apb(1'b0, mfx_pkg::REG_STATUS, 32'h0);
		check(r, 32'h00125000);
		u_mfx_core_model.iot(12'hca4, 12'h000);
		phx(3'h1, 3'h1, 12'h002, 3'h0);
		phx(3'h2, 3'h1, 12'h020, 3'h0);
		phx(3'h4, 3'h1, 12'h400, 3'h5);
		u_mfx_core_model.jump_op;
		phx(3'h1, 3'h0, 12'h003, 3'h4);
	endtask : t_int
	task t_panel;
		u_mfx_core_model.lvl(1'b0, 1'b1, 1'b1);
		repeat (2) @(posedge clk);
		check(pgr, 1'b1);
		u_mfx_core_model.iot(12'hc92, 12'h000);
		u_mfx_core_model.jump_op;
		phx(3'h1, 3'h0, 12'h004, 3'h4);
		u_mfx_core_model.iot(12'hcac, 12'h000);
		phx(3'h1, 3'h0, 12'h005, 3'h2);
		u_mfx_core_model.lvl(1'b0, 1'b0, 1'b0);
		rd(12'hc8c, 12'h801, 12'h829);
		rd(12'hc94, 12'h801, 12'h811);
		check(pgr, 1'b0);
	endtask : t_panel
	// unmapped access, then the extension switched off and on again
	task t_apb;
		apb(1'b0, 12'h008, 32'h0);
		check(r, 32'h00000000);
		check(e, 1'b1);
		apb(1'b1, mfx_pkg::REG_CTRL, 32'h0);
		phx(3'h1, 3'h0, 12'h006, 3'h0);
		apb(1'b1, mfx_pkg::REG_CTRL, mfx_pkg::CTRL_RESET);
		apb(1'b0, mfx_pkg::REG_CTRL, 32'h0);
		check(r, mfx_pkg::CTRL_RESET);
		check(e, 1'b0);
	endtask : t_apb
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		rst_n = 1'b0;
		apb_q = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_fields;
		t_int;
		t_panel;
		t_apb;
		report_and_stop;
	end
	// a hang well past the expected 120 or so cycles ends the run
	initial begin
		#200000;
		fail_count++;
		report_and_stop;
	end
endmodule : tb_top
